// *** common/lprc_pkg.sv ***
// constants, types and helpers shared by the real-time counter files
`default_nettype none
package lprc_pkg;

	// register indexes; byte address is four times the index
	localparam logic [3:0] LPRC_IDX_DIVIDER = 4'h0;
	localparam logic [3:0] LPRC_IDX_SYNC_STATE = 4'h1;
	localparam logic [3:0] LPRC_IDX_IRQ_LEVEL = 4'h2;
	localparam logic [3:0] LPRC_IDX_IRQ_FLAGS = 4'h3;
	localparam logic [3:0] LPRC_IDX_STAGING = 4'h4;
	localparam logic [3:0] LPRC_IDX_COUNT_LO = 4'h8;
	localparam logic [3:0] LPRC_IDX_COUNT_HI = 4'h9;
	localparam logic [3:0] LPRC_IDX_LIMIT_LO = 4'ha;
	localparam logic [3:0] LPRC_IDX_LIMIT_HI = 4'hb;
	localparam logic [3:0] LPRC_IDX_MATCH_LO = 4'hc;
	localparam logic [3:0] LPRC_IDX_MATCH_HI = 4'hd;

	// field positions
	localparam int LPRC_DIV_LSB = 0;
	localparam int LPRC_WRAP_LVL_LSB = 0;
	localparam int LPRC_MATCH_LVL_LSB = 2;
	localparam int LPRC_WRAP_FLAG_BIT = 0;
	localparam int LPRC_MATCH_FLAG_BIT = 1;
	localparam int LPRC_SYNC_BIT = 0;

	// reset values
	localparam logic [2:0] LPRC_DIV_RST = 3'h0;
	localparam logic [3:0] LPRC_LVL_RST = 4'h0;
	localparam logic [15:0] LPRC_COUNT_RST = 16'h0000;
	localparam logic [15:0] LPRC_LIMIT_RST = 16'hffff;
	localparam logic [15:0] LPRC_MATCH_RST = 16'h0000;
	localparam logic [7:0] LPRC_STAGING_RST = 8'h00;

	// timing: reference-clock edges a written value waits before it acts
	localparam logic [1:0] LPRC_SYNC_TICKS = 2'h2;

	typedef enum logic [2:0] {
		LPRC_DIV_OFF = 3'b000,
		LPRC_DIV_1 = 3'b001,
		LPRC_DIV_2 = 3'b010,
		LPRC_DIV_8 = 3'b011,
		LPRC_DIV_16 = 3'b100,
		LPRC_DIV_64 = 3'b101,
		LPRC_DIV_256 = 3'b110,
		LPRC_DIV_1024 = 3'b111
	} lprc_div_t;

	typedef enum logic [1:0] {
		LPRC_TGT_COUNT = 2'b00,
		LPRC_TGT_LIMIT = 2'b01,
		LPRC_TGT_MATCH = 2'b10,
		LPRC_TGT_DIVIDER = 2'b11
	} lprc_tgt_t;

	typedef enum logic {
		LPRC_SYNC_IDLE = 1'b0,
		LPRC_SYNC_WAIT = 1'b1
	} lprc_sync_t;

	// low bits that must all be one before a divided tick is let through
	function automatic logic [9:0] lprc_div_mask(input logic [2:0] sel);
		case (sel)
			LPRC_DIV_2: lprc_div_mask = 10'h001;
			LPRC_DIV_8: lprc_div_mask = 10'h007;
			LPRC_DIV_16: lprc_div_mask = 10'h00f;
			LPRC_DIV_64: lprc_div_mask = 10'h03f;
			LPRC_DIV_256: lprc_div_mask = 10'h0ff;
			LPRC_DIV_1024: lprc_div_mask = 10'h3ff;
			default: lprc_div_mask = 10'h000;
		endcase
	endfunction

	// true when this occurrence must also leave as an event
	function automatic logic lprc_event_due(input logic [1:0] seen, input logic [15:0] limit);
		logic [1:0] need;
		need = (limit == 16'h0000) ? 2'h3 : ((limit == 16'h0001) ? 2'h2 : 2'h1);
		lprc_event_due = ((seen + 2'h1) >= need);
	endfunction

endpackage
`default_nettype wire

// *** rtl/lprc_prescaler.sv ***
// reference-clock edge finder and power-of-two prescaler
`timescale 1ns/100ps
`default_nettype none
module lprc_prescaler
	import lprc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// reference clock and divider choice
	input wire logic rtc_clk_in,
	input wire logic [2:0] div_sel,
	// ticks
	output logic ref_tick,
	output logic count_tick
);

	typedef struct packed {
		logic ref_prev;
		logic [9:0] ticks;
	} lprc_pre_state_t;

	lprc_pre_state_t s_r;
	lprc_pre_state_t s_nxt;
	logic [9:0] mask;

	always_comb begin
		mask = lprc_div_mask(div_sel);
		ref_tick = clk_en & rtc_clk_in & ~s_r.ref_prev;
		// off stops the counter entirely
		count_tick = ref_tick && (div_sel != LPRC_DIV_OFF) && ((s_r.ticks & mask) == mask);
		s_nxt = s_r;
		s_nxt.ref_prev = rtc_clk_in;
		if (ref_tick) begin
			s_nxt.ticks = (div_sel == LPRC_DIV_OFF) ? 10'h000 : s_r.ticks + 10'h001;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

endmodule
`default_nettype wire

// *** rtl/lprc_top.sv ***
// real-time counter: wishbone registers, sync path, counter, flags, events
// Behaviour
// - divider code 000 stops, else divide 1..1024
// - 16-bit count rises per divided tick
// - tick at wrap limit: zero count, wrap
// - tick at match value raises match
// - events thinned when wrap limit below two
// - match above wrap limit never matches
// - sync pending flag covers register crossings
// - count, limit, match, divider writes act two reference ticks later
// - bits 3:2 give match interrupt level
// - bits 1:0 give wrap interrupt level
// - match flag bit 1, vector or w1c
// - wrap flag bit 0, vector or w1c
// - low write stages, low read stages high
// - counter side paced by reference clock
`timescale 1ns/100ps
`default_nettype none
module lprc_top
	import lprc_pkg::*;
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// reference clock for the counter
	input wire logic rtc_clk_in,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// interrupt requests towards the controller
	output logic [1:0] wrap_irq_level,
	output logic wrap_irq_req,
	input wire logic wrap_vect_taken,
	output logic [1:0] match_irq_level,
	output logic match_irq_req,
	input wire logic match_vect_taken,
	// events
	output logic wrap_event,
	output logic match_event,
	// live count
	output logic [15:0] count_value
);

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		logic [7:0] staging;
		logic [2:0] div_written;
		logic [2:0] div_live;
		logic [3:0] irq_level;
		logic wrap_flag;
		logic match_flag;
		logic [15:0] count;
		logic [15:0] wrap_limit;
		logic [15:0] match_value;
		lprc_sync_t sync;
		lprc_tgt_t pend_tgt;
		logic [15:0] pend_val;
		logic [1:0] pend_ticks;
		logic [1:0] wrap_seen;
		logic [1:0] match_seen;
		logic wrap_ev;
		logic match_ev;
	} lprc_state_t;

	lprc_state_t s_r;
	lprc_state_t s_nxt;

	logic ref_tick;
	logic count_tick;
	logic bus_hit;
	logic adr_ok;
	logic wr_lo;
	logic [3:0] idx;
	logic [7:0] wbyte;
	logic applying;
	logic hit_limit;
	logic hit_match;
	logic clr_wrap;
	logic clr_match;
	logic sync_write;

	////////////////////////////////////////////////////////////////////////////
	// prescaler on the reference clock
	lprc_prescaler u_prescaler (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.rtc_clk_in(rtc_clk_in),
		.div_sel(s_r.div_live),
		.ref_tick(ref_tick),
		.count_tick(count_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// register read mux, kept apart so the bus path stays readable
	function automatic logic [7:0] read_byte(input lprc_state_t s, input logic [3:0] i);
		case (i)
			LPRC_IDX_DIVIDER: read_byte = {5'h00, s.div_written};
			LPRC_IDX_SYNC_STATE: read_byte = {7'h00, s.sync == LPRC_SYNC_WAIT};
			LPRC_IDX_IRQ_LEVEL: read_byte = {4'h0, s.irq_level};
			LPRC_IDX_IRQ_FLAGS: read_byte = {6'h00, s.match_flag, s.wrap_flag};
			LPRC_IDX_STAGING: read_byte = s.staging;
			LPRC_IDX_COUNT_LO: read_byte = s.count[7:0];
			LPRC_IDX_LIMIT_LO: read_byte = s.wrap_limit[7:0];
			LPRC_IDX_MATCH_LO: read_byte = s.match_value[7:0];
			// high halves come back through the staging byte
			LPRC_IDX_COUNT_HI: read_byte = s.staging;
			LPRC_IDX_LIMIT_HI: read_byte = s.staging;
			LPRC_IDX_MATCH_HI: read_byte = s.staging;
			default: read_byte = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.wrap_ev = 1'b0;
		s_nxt.match_ev = 1'b0;
		idx = wb_adr_i[5:2];
		adr_ok = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i[7:6] == 2'b00);
		bus_hit = wb_cyc_i & wb_stb_i & ~s_r.ack;
		wr_lo = bus_hit & wb_we_i & wb_sel_i[0] & adr_ok;
		wbyte = wb_dat_i[7:0];
		applying = 1'b0;
		hit_limit = 1'b0;
		hit_match = 1'b0;
		clr_wrap = wrap_vect_taken;
		clr_match = match_vect_taken;
		// only writes to crossing registers restart the wait; a level or
		// flag write in the same cycle must not stall a pending value
		sync_write = 1'b0;

		// bus: one-shot side effects on the first cycle of each request
		if (bus_hit) begin
			s_nxt.ack = 1'b1;
			s_nxt.rdata = adr_ok ? read_byte(s_r, idx) : 8'h00;
			if (!wb_we_i && adr_ok) begin
				case (idx)
					LPRC_IDX_COUNT_LO: s_nxt.staging = s_r.count[15:8];
					LPRC_IDX_LIMIT_LO: s_nxt.staging = s_r.wrap_limit[15:8];
					LPRC_IDX_MATCH_LO: s_nxt.staging = s_r.match_value[15:8];
					default: s_nxt.staging = s_nxt.staging;
				endcase
			end
		end

		if (wr_lo) begin
			case (idx)
				LPRC_IDX_DIVIDER: begin
					s_nxt.div_written = wbyte[LPRC_DIV_LSB +: 3];
					s_nxt.pend_tgt = LPRC_TGT_DIVIDER;
					sync_write = 1'b1;
					s_nxt.pend_val = {13'h0000, wbyte[LPRC_DIV_LSB +: 3]};
					s_nxt.pend_ticks = 2'h0;
					s_nxt.sync = LPRC_SYNC_WAIT;
				end
				LPRC_IDX_IRQ_LEVEL: s_nxt.irq_level = wbyte[3:0];
				LPRC_IDX_IRQ_FLAGS: begin
					clr_wrap = clr_wrap | wbyte[LPRC_WRAP_FLAG_BIT];
					clr_match = clr_match | wbyte[LPRC_MATCH_FLAG_BIT];
				end
				LPRC_IDX_STAGING: s_nxt.staging = wbyte;
				LPRC_IDX_COUNT_LO: s_nxt.staging = wbyte;
				LPRC_IDX_LIMIT_LO: s_nxt.staging = wbyte;
				LPRC_IDX_MATCH_LO: s_nxt.staging = wbyte;
				LPRC_IDX_COUNT_HI: begin
					s_nxt.pend_tgt = LPRC_TGT_COUNT;
					sync_write = 1'b1;
					s_nxt.pend_val = {wbyte, s_r.staging};
					s_nxt.pend_ticks = 2'h0;
					s_nxt.sync = LPRC_SYNC_WAIT;
				end
				LPRC_IDX_LIMIT_HI: begin
					s_nxt.pend_tgt = LPRC_TGT_LIMIT;
					sync_write = 1'b1;
					s_nxt.pend_val = {wbyte, s_r.staging};
					s_nxt.pend_ticks = 2'h0;
					s_nxt.sync = LPRC_SYNC_WAIT;
				end
				LPRC_IDX_MATCH_HI: begin
					s_nxt.pend_tgt = LPRC_TGT_MATCH;
					sync_write = 1'b1;
					s_nxt.pend_val = {wbyte, s_r.staging};
					s_nxt.pend_ticks = 2'h0;
					s_nxt.sync = LPRC_SYNC_WAIT;
				end
				default: s_nxt.staging = s_nxt.staging;
			endcase
		end

		////////////////////////////////////////////////////////////////////////
		// crossing: a staged value reaches the counter side only on reference
		// edges; a new write while waiting simply restarts the wait
		case (s_r.sync)
			LPRC_SYNC_IDLE: s_nxt.pend_ticks = s_nxt.pend_ticks;
			LPRC_SYNC_WAIT: begin
				if (ref_tick && !sync_write) begin
					if (s_r.pend_ticks == LPRC_SYNC_TICKS - 2'h1) begin
						applying = 1'b1;
						s_nxt.sync = LPRC_SYNC_IDLE;
						case (s_r.pend_tgt)
							LPRC_TGT_COUNT: s_nxt.count = s_r.pend_val;
							LPRC_TGT_LIMIT: s_nxt.wrap_limit = s_r.pend_val;
							LPRC_TGT_MATCH: s_nxt.match_value = s_r.pend_val;
							default: s_nxt.div_live = s_r.pend_val[2:0];
						endcase
					end else begin
						s_nxt.pend_ticks = s_r.pend_ticks + 2'h1;
					end
				end
			end
			default: s_nxt.sync = LPRC_SYNC_IDLE;
		endcase

		////////////////////////////////////////////////////////////////////////
		// counting; a count load landing on the same tick wins
		if (count_tick) begin
			hit_limit = (s_r.count == s_r.wrap_limit);
			// compare above the limit is unreachable by design
			hit_match = (s_r.count == s_r.match_value) && (s_r.match_value <= s_r.wrap_limit);
			if (!(applying && s_r.pend_tgt == LPRC_TGT_COUNT)) begin
				s_nxt.count = hit_limit ? 16'h0000 : s_r.count + 16'h0001;
			end
			if (hit_limit) begin
				s_nxt.wrap_ev = lprc_event_due(s_r.wrap_seen, s_r.wrap_limit);
				s_nxt.wrap_seen = s_nxt.wrap_ev ? 2'h0 : s_r.wrap_seen + 2'h1;
			end
			if (hit_match) begin
				s_nxt.match_ev = lprc_event_due(s_r.match_seen, s_r.wrap_limit);
				s_nxt.match_seen = s_nxt.match_ev ? 2'h0 : s_r.match_seen + 2'h1;
			end
		end

		////////////////////////////////////////////////////////////////////////
		// flags: a set in the same cycle as a clear wins
		if (clr_wrap) begin
			s_nxt.wrap_flag = 1'b0;
		end
		if (clr_match) begin
			s_nxt.match_flag = 1'b0;
		end
		if (hit_limit) begin
			s_nxt.wrap_flag = 1'b1;
		end
		if (hit_match) begin
			s_nxt.match_flag = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; enable low freezes everything
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r.ack <= 1'b0;
			s_r.rdata <= 8'h00;
			s_r.staging <= LPRC_STAGING_RST;
			s_r.div_written <= LPRC_DIV_RST;
			s_r.div_live <= LPRC_DIV_RST;
			s_r.irq_level <= LPRC_LVL_RST;
			s_r.wrap_flag <= 1'b0;
			s_r.match_flag <= 1'b0;
			s_r.count <= LPRC_COUNT_RST;
			s_r.wrap_limit <= LPRC_LIMIT_RST;
			s_r.match_value <= LPRC_MATCH_RST;
			s_r.sync <= LPRC_SYNC_IDLE;
			s_r.pend_tgt <= LPRC_TGT_COUNT;
			s_r.pend_val <= 16'h0000;
			s_r.pend_ticks <= 2'h0;
			s_r.wrap_seen <= 2'h0;
			s_r.match_seen <= 2'h0;
			s_r.wrap_ev <= 1'b0;
			s_r.match_ev <= 1'b0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	always_comb begin
		wb_dat_o = {24'h000000, s_r.rdata};
		wb_ack_o = s_r.ack;
		wrap_irq_level = s_r.irq_level[LPRC_WRAP_LVL_LSB +: 2];
		match_irq_level = s_r.irq_level[LPRC_MATCH_LVL_LSB +: 2];
		// level zero means disabled
		wrap_irq_req = s_r.wrap_flag && (wrap_irq_level != 2'h0);
		match_irq_req = s_r.match_flag && (match_irq_level != 2'h0);
		wrap_event = s_r.wrap_ev;
		match_event = s_r.match_ev;
		count_value = s_r.count;
	end

endmodule
`default_nettype wire

// *** testbench/lprc_assertions.sv ***
// port checker for the real-time counter
`timescale 1ns/100ps
`default_nettype none
module lprc_assertions (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// requests, events, count
	input wire logic [1:0] wrap_irq_level,
	input wire logic wrap_irq_req,
	input wire logic wrap_vect_taken,
	input wire logic [1:0] match_irq_level,
	input wire logic match_irq_req,
	input wire logic match_vect_taken,
	input wire logic wrap_event,
	input wire logic match_event,
	input wire logic [15:0] count_value
);
////////////////////////////////////////
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	ack_pulse_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
		else $error("request not answered next cycle");
	dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	wrap_off_a: assert property (wrap_irq_level == 2'h0 |-> !wrap_irq_req)
		else $error("wrap request while disabled");
	match_off_a: assert property (match_irq_level == 2'h0 |-> !match_irq_req)
		else $error("match request while disabled");
	wrap_req_a: assert property (wrap_event && wrap_irq_level != 2'h0 |-> wrap_irq_req)
		else $error("wrap event without request");
	match_req_a: assert property (match_event && match_irq_level != 2'h0 |-> match_irq_req)
		else $error("match event without request");
	wrap_clear_a: assert property (wrap_vect_taken && clk_en |=> wrap_event || !wrap_irq_req)
		else $error("wrap flag kept after vector");
	match_clear_a: assert property (match_vect_taken && clk_en |=> match_event || !match_irq_req)
		else $error("match flag kept after vector");
	wrap_zero_a: assert property ($rose(wrap_event) |-> count_value == 16'h0)
		else $error("count not zero at wrap");
	event_pulse_a: assert property (wrap_event && clk_en |=> !wrap_event)
		else $error("wrap event longer than one cycle");
	match_pulse_a: assert property (match_event && clk_en |=> !match_event)
		else $error("match event longer than one cycle");
endmodule
////////////////////////////////////////
bind lprc_top lprc_assertions chk_u (
	.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.wrap_irq_level(wrap_irq_level), .wrap_irq_req(wrap_irq_req),
	.wrap_vect_taken(wrap_vect_taken), .match_irq_level(match_irq_level),
	.match_irq_req(match_irq_req), .match_vect_taken(match_vect_taken),
	.wrap_event(wrap_event), .match_event(match_event), .count_value(count_value)
);
`default_nettype wire

// *** testbench/lprc_top_tb.sv ***
// self-checking bench for the real-time counter
`timescale 1ns/100ps
`default_nettype none
module lprc_top_tb;
	logic core_clk, sys_rst, clk_en, rtc_clk_in, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic wrap_vect_taken, match_vect_taken, wrap_irq_req, match_irq_req, wrap_event, match_event;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, mcnt;
	logic [1:0] wrap_irq_level, match_irq_level;
	logic [15:0] count_value;
	int fail_count, tests_run;
	lprc_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.rtc_clk_in(rtc_clk_in), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wrap_irq_level(wrap_irq_level), .wrap_irq_req(wrap_irq_req),
		.wrap_vect_taken(wrap_vect_taken), .match_irq_level(match_irq_level),
		.match_irq_req(match_irq_req), .match_vect_taken(match_vect_taken),
		.wrap_event(wrap_event), .match_event(match_event), .count_value(count_value));
////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// reference tick every 4 cycles, slow enough for the edge finder
	initial begin
		rtc_clk_in = 1'b0;
		forever begin
			repeat (2) @(posedge core_clk);
			rtc_clk_in <= ~rtc_clk_in;
		end
	end
	always @(posedge core_clk) begin
		if (sys_rst) begin
			mcnt <= 32'h0;
		end else if (match_event === 1'b1) begin
			mcnt <= mcnt + 32'h1;
		end
	end
////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= 4'h1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		q = wb_dat_o;
		check({31'h0, wb_ack_o}, 32'h1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h0, q);
		check(q, e);
	endtask
	task automatic sync_wait();
		logic [31:0] q;
		int n;
		bus(1'b0, 8'h04, 8'h0, q);
		check(q, 32'h1);
		n = 0;
		while (q !== 32'h0 && n < 40) begin
			bus(1'b0, 8'h04, 8'h0, q);
			n++;
		end
		check(q, 32'h0);
	endtask
	task automatic w16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h04, v[15:8]);
		sync_wait();
	endtask
	// cycles between two wrap events
	task automatic gap(output logic [31:0] c);
		int k;
		k = 0;
		while (wrap_event !== 1'b1 && k < 20000) begin
			@(posedge core_clk);
			k++;
		end
		c = 32'h0;
		do begin
			@(posedge core_clk);
			c++;
		end while (wrap_event !== 1'b1 && c < 32'd20000);
	endtask
////////////////////////////////////////
	task automatic t_reset();
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h28, 32'hff);
		rd(8'h2c, 32'hff);
		wr(8'h3c, 8'h5a);
		rd(8'h3c, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_count();
		wr(8'h20, 8'h34);
		wr(8'h24, 8'h12);
		check({16'h0, count_value}, 32'h0);
		sync_wait();
		check({16'h0, count_value}, 32'h1234);
		rd(8'h20, 32'h34);
		rd(8'h10, 32'h12);
		rd(8'h24, 32'h12);
		repeat (100) @(posedge core_clk);
		check({16'h0, count_value}, 32'h1234);
		$display("count test done");
	endtask
	task automatic t_divide();
		logic [31:0] c;
		logic [15:0] lim [9] = '{2, 2, 2, 2, 2, 2, 2, 0, 1};
		logic [7:0] code [9] = '{1, 2, 3, 4, 5, 6, 7, 1, 1};
		logic [31:0] want [9] = '{12, 24, 96, 192, 768, 3072, 12288, 12, 16};
		for (int i = 0; i < 9; i++) begin
			w16(8'h28, lim[i]);
			w16(8'h20, 16'h0);
			wr(8'h00, code[i]);
			sync_wait();
			gap(c);
			check(c, want[i]);
		end
		$display("divider test done");
	endtask
	task automatic t_flags();
		logic [31:0] c;
		logic [31:0] m;
		wr(8'h08, 8'h05);
		rd(8'h08, 32'h05);
		w16(8'h28, 16'h0005);
		w16(8'h30, 16'h0003);
		w16(8'h20, 16'h0);
		wr(8'h0c, 8'h03);
		m = mcnt;
		gap(c);
		check(c, 32'd24);
		check({31'h0, mcnt != m}, 32'h1);
		check({28'h0, match_irq_level, wrap_irq_level}, 32'h5);
		check({30'h0, match_irq_req, wrap_irq_req}, 32'h3);
		wrap_vect_taken <= 1'b1;
		match_vect_taken <= 1'b1;
		@(posedge core_clk);
		wrap_vect_taken <= 1'b0;
		match_vect_taken <= 1'b0;
		@(posedge core_clk);
		check({30'h0, match_irq_req, wrap_irq_req}, 32'h0);
		gap(c);
		wr(8'h00, 8'h00);
		sync_wait();
		rd(8'h0c, 32'h03);
		wr(8'h0c, 8'h01);
		rd(8'h0c, 32'h02);
		wr(8'h0c, 8'h02);
		rd(8'h0c, 32'h00);
		$display("flag test done");
	endtask
	task automatic t_nomatch();
		logic [31:0] m;
		// count starts below a match value above the limit, so it runs past it
		w16(8'h28, 16'h0002);
		w16(8'h30, 16'h0005);
		w16(8'h20, 16'h0004);
		wr(8'h00, 8'h01);
		sync_wait();
		wr(8'h0c, 8'h03);
		m = mcnt;
		repeat (200) @(posedge core_clk);
		check({31'h0, count_value > 16'h0005}, 32'h1);
		check(mcnt, m);
		rd(8'h0c, 32'h00);
		$display("no-match test done");
	endtask
	task automatic t_freeze();
		logic [15:0] v;
		@(posedge core_clk);
		clk_en <= 1'b0;
		@(posedge core_clk);
		v = count_value;
		repeat (40) @(posedge core_clk);
		check({16'h0, count_value}, {16'h0, v});
		clk_en <= 1'b1;
		repeat (40) @(posedge core_clk);
		check({31'h0, count_value != v}, 32'h1);
		$display("freeze test done");
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
////////////////////////////////////////
	initial begin
		{sys_rst, clk_en, wb_sel_i} = 6'h31;
		{wb_cyc_i, wb_stb_i, wb_we_i, wrap_vect_taken, match_vect_taken} = 5'h0;
		wb_adr_i = 8'h0;
		wb_dat_i = 32'h0;
		fail_count = 0;
		tests_run = 0;
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_count();
		t_divide();
		t_flags();
		t_nomatch();
		t_freeze();
		report_and_stop();
	end
	// run needs about 34k cycles; give up at 90k
	initial begin
		#900000;
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
